// File: hdl/ddrcmd_params.svh
`ifndef DDRCMD_PARAMS_SVH
`define DDRCMD_PARAMS_SVH
`define DDRCMD_NBANK 8
`define DDRCMD_ROW_W 16
`define DDRCMD_COL_W 10
`define DDRCMD_DQ_W 8
`define DDRCMD_MEM_AW 8
`define DDRCMD_CLK_MHZ 50
`define DDRCMD_T_RP_NS 14
`define DDRCMD_T_RFC_NS 260
`define DDRCMD_T_ZQINIT_CK 512
`define DDRCMD_T_ZQOPER_CK 256
`define DDRCMD_T_ZQCS_CK 64
`define DDRCMD_T_RP_CK ((`DDRCMD_T_RP_NS * `DDRCMD_CLK_MHZ + 999) / 1000)
`define DDRCMD_T_RFC_CK ((`DDRCMD_T_RFC_NS * `DDRCMD_CLK_MHZ + 999) / 1000)
`define DDRCMD_SR_TICK_CK 390
`define DDRCMD_A10 10
`define DDRCMD_A12 12
`define DDRCMD_ZQ_RST 8'h40
`endif

// File: hdl/ddrcmd_pkg.sv
package ddrcmd_pkg;
   typedef enum logic [1:0] {
      ddrcmd_bank_idle = 2'b00,
      ddrcmd_bank_act = 2'b01,
      ddrcmd_bank_pre = 2'b11
   } ddrcmd_bank_t;
   typedef enum logic [3:0] {
      ddrcmd_op_none, ddrcmd_op_act, ddrcmd_op_rd, ddrcmd_op_wr, ddrcmd_op_pre,
      ddrcmd_op_ref, ddrcmd_op_sre, ddrcmd_op_zql, ddrcmd_op_zqs, ddrcmd_op_mrs
   } ddrcmd_op_t;
   typedef enum logic [1:0] {
      ddrcmd_mode_run = 2'b00,
      ddrcmd_mode_busy = 2'b01,
      ddrcmd_mode_self = 2'b11
   } ddrcmd_mode_t;
endpackage

// File: hdl/ddrcmd_buf2.sv
`timescale 1ns/1ps
`include "ddrcmd_params.svh"
module ddrcmd_buf2 (
   input wire logic clk_sys, // Clock
   input wire logic sys_rst, // Async reset
   input wire logic clk_en, // Freeze when low
   input wire logic [`DDRCMD_DQ_W-1:0] in_data, // Word in
   input wire logic in_valid, // Word offered
   output logic in_ready, // Room available
   output logic [`DDRCMD_DQ_W-1:0] out_data, // Word out
   output logic out_valid, // Word held
   input wire logic out_ready // Receiver takes
);
   logic [`DDRCMD_DQ_W-1:0] mem [0:1];
   logic wp, rp;
   logic [1:0] cnt;
   logic push, pop;
   assign push = in_valid && (cnt != 2'h2);
   assign pop = out_valid && out_ready;
   assign in_ready = (cnt != 2'h2);
   assign out_valid = (cnt != 2'h0);
   assign out_data = mem[rp];
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         wp <= 1'b0;
         rp <= 1'b0;
         cnt <= 2'h0;
         mem[0] <= '0;
         mem[1] <= '0;
      end else if (clk_en) begin
         if (push) begin
            mem[wp] <= in_data;
            wp <= ~wp;
         end
         if (pop) rp <= ~rp;
         cnt <= cnt + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule

// File: hdl/ddrcmd_core.sv
`timescale 1ns/1ps
`include "ddrcmd_params.svh"
// Overview of operation
// - Decode command from strobes at clock edge
// - Deselect and no-op register nothing new
// - Long calibration, init then operational window
// - Short calibration within 64 clocks
// - Activate opens row in selected bank
// - Read: low column bits, A10 autoprecharge
// - A12 chooses chop or eight beats
// - Read bursts run to completion
// - Write: bank select, A10, burst start
// - Mask high discards byte, low stores
// - Bank ready after precharge period
// - Other-bank access during auto precharge
// - A10 selects all-bank or single precharge
// - Idle precharge is no-op, retimes period
// - Refresh uses internal row, timed period
// - Self refresh keeps data without clock
module ddrcmd_core (
   input wire logic clk_sys, // System clock
   input wire logic sys_rst, // Async reset, high
   input wire logic clk_en, // Freeze when low
   input wire logic cs_n_pin, // Chip select pin
   input wire logic ras_n_pin, // Row strobe pin
   input wire logic cas_n_pin, // Column strobe pin
   input wire logic we_n_pin, // Write enable pin
   input wire logic cke_pin, // Clock enable pin
   input wire logic [2:0] ba_pin, // Bank address pins
   input wire logic [`DDRCMD_ROW_W-1:0] addr_pin, // Address pins
   input wire logic [`DDRCMD_DQ_W-1:0] dq_in_pin, // Write data pins
   input wire logic dm_pin, // Data mask pin
   input wire logic otf_en, // On-the-fly burst enable
   input wire logic bc4_fixed, // Fixed chop when otf off
   output logic [`DDRCMD_DQ_W-1:0] rd_data, // Read data word
   output logic rd_valid, // Read word valid
   input wire logic rd_ready, // Receiver ready
   output logic [7:0] zq_value, // Applied impedance code
   output logic zq_busy, // Calibration in progress
   output logic [`DDRCMD_NBANK-1:0] bank_open, // Bank has open row
   output logic self_refresh, // In self refresh
   output logic [`DDRCMD_ROW_W-1:0] ref_row, // Internal refresh row
   output logic cmd_error // Illegal command seen
);
   logic [4:0] s1, s2;
   logic [2:0] ba1, ba2;
   logic [`DDRCMD_ROW_W-1:0] a1, a2;
   logic [`DDRCMD_DQ_W-1:0] dq1, dq2;
   logic dm1, dm2, cke_prev;
   ddrcmd_pkg::ddrcmd_op_t op;
   ddrcmd_pkg::ddrcmd_op_t op_run;
   logic out_take;
   ddrcmd_pkg::ddrcmd_bank_t bstate [`DDRCMD_NBANK];
   logic [`DDRCMD_ROW_W-1:0] brow [`DDRCMD_NBANK];
   logic [`DDRCMD_NBANK-1:0] bap;
   logic [7:0] btmr [`DDRCMD_NBANK];
   logic [`DDRCMD_DQ_W-1:0] mem [0:(1<<`DDRCMD_MEM_AW)-1];
   logic bur_act, bur_wr, bur_ap;
   logic [2:0] bur_bank;
   logic [3:0] bur_left;
   logic [`DDRCMD_MEM_AW-1:0] bur_addr;
   ddrcmd_pkg::ddrcmd_mode_t mode;
   logic [8:0] busy_cnt;
   logic [9:0] sr_cnt;
   logic zq_init_done;
   logic [7:0] zq_work;
   logic buf_in_ready, buf_out_valid;
   logic [`DDRCMD_DQ_W-1:0] buf_out_data;
   logic rd_push;
   logic [3:0] next_len;
   logic [`DDRCMD_MEM_AW-1:0] next_addr;

   // Two-stage input synchronisers
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         s1 <= 5'h1f;
         s2 <= 5'h1f;
         ba1 <= 3'h0;
         ba2 <= 3'h0;
         a1 <= '0;
         a2 <= '0;
         dq1 <= '0;
         dq2 <= '0;
         dm1 <= 1'b1;
         dm2 <= 1'b1;
         cke_prev <= 1'b1;
      end else if (clk_en) begin
         s1 <= {cke_pin, cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin};
         s2 <= s1;
         ba1 <= ba_pin;
         ba2 <= ba1;
         a1 <= addr_pin;
         a2 <= a1;
         dq1 <= dq_in_pin;
         dq2 <= dq1;
         dm1 <= dm_pin;
         dm2 <= dm1;
         cke_prev <= s2[4];
      end
   end

   always_comb begin
      op = ddrcmd_pkg::ddrcmd_op_none;
      if (cke_prev && !s2[3]) begin
         case (s2[2:0])
            3'b011: op = ddrcmd_pkg::ddrcmd_op_act;
            3'b101: op = ddrcmd_pkg::ddrcmd_op_rd;
            3'b100: op = ddrcmd_pkg::ddrcmd_op_wr;
            3'b010: op = ddrcmd_pkg::ddrcmd_op_pre;
            3'b001: op = s2[4] ? ddrcmd_pkg::ddrcmd_op_ref : ddrcmd_pkg::ddrcmd_op_sre;
            3'b110: op = a2[`DDRCMD_A10] ? ddrcmd_pkg::ddrcmd_op_zql :
                         ddrcmd_pkg::ddrcmd_op_zqs;
            3'b000: op = ddrcmd_pkg::ddrcmd_op_mrs;
            default: op = ddrcmd_pkg::ddrcmd_op_none;
         endcase
      end
   end

   // Commands arriving during refresh or calibration change nothing but cmd_error
   assign op_run = (mode == ddrcmd_pkg::ddrcmd_mode_busy) ? ddrcmd_pkg::ddrcmd_op_none : op;

   // Burst length and start address
   always_comb begin
      if (otf_en) next_len = a2[`DDRCMD_A12] ? 4'h8 : 4'h4;
      else next_len = bc4_fixed ? 4'h4 : 4'h8;
      next_addr = {ba2, brow[ba2][1:0], a2[2:0]};
   end

   // Per-bank state tracking
   genvar g;
   generate
      for (g = 0; g < `DDRCMD_NBANK; g++) begin : g_bank
         logic hit, pre_hit, ap_done;
         assign hit = (ba2 == g[2:0]);
         assign pre_hit = (op_run == ddrcmd_pkg::ddrcmd_op_pre) &&
                          (a2[`DDRCMD_A10] || hit);
         assign ap_done = bap[g] && !(bur_act && bur_bank == g[2:0]);
         always_ff @(posedge clk_sys or posedge sys_rst) begin
            if (sys_rst) begin
               bstate[g] <= ddrcmd_pkg::ddrcmd_bank_idle;
               brow[g] <= '0;
               bap[g] <= 1'b0;
               btmr[g] <= 8'h0;
            end else if (clk_en) begin
               if (op_run == ddrcmd_pkg::ddrcmd_op_act && hit &&
                   bstate[g] == ddrcmd_pkg::ddrcmd_bank_idle) begin
                  bstate[g] <= ddrcmd_pkg::ddrcmd_bank_act;
                  brow[g] <= a2;
               end else if (pre_hit) begin
                  // Restart period even when already idle or precharging
                  btmr[g] <= 8'(`DDRCMD_T_RP_CK);
                  if (bstate[g] == ddrcmd_pkg::ddrcmd_bank_act)
                     bstate[g] <= ddrcmd_pkg::ddrcmd_bank_pre;
                  bap[g] <= 1'b0;
               end else if (ap_done) begin
                  bap[g] <= 1'b0;
                  bstate[g] <= ddrcmd_pkg::ddrcmd_bank_pre;
                  btmr[g] <= 8'(`DDRCMD_T_RP_CK);
               end else if (bstate[g] == ddrcmd_pkg::ddrcmd_bank_pre) begin
                  if (btmr[g] <= 8'h1) begin
                     bstate[g] <= ddrcmd_pkg::ddrcmd_bank_idle;
                     btmr[g] <= 8'h0;
                  end else begin
                     btmr[g] <= btmr[g] - 8'h1;
                  end
               end else if (btmr[g] != 8'h0) begin
                  btmr[g] <= btmr[g] - 8'h1;
               end
               if ((op_run == ddrcmd_pkg::ddrcmd_op_rd || op_run == ddrcmd_pkg::ddrcmd_op_wr) &&
                   hit && a2[`DDRCMD_A10] && bstate[g] == ddrcmd_pkg::ddrcmd_bank_act)
                  bap[g] <= 1'b1;
            end
         end
      end
   endgenerate

   // Burst engine, reads and masked writes
   assign rd_push = bur_act && !bur_wr && buf_in_ready;
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         bur_act <= 1'b0;
         bur_wr <= 1'b0;
         bur_ap <= 1'b0;
         bur_bank <= 3'h0;
         bur_left <= 4'h0;
         bur_addr <= '0;
      end else if (clk_en) begin
         if (bur_act) begin
            // Running burst ignores later commands
            if (bur_wr || buf_in_ready) begin
               bur_addr <= bur_addr + 1'b1;
               bur_left <= bur_left - 4'h1;
               if (bur_left == 4'h1) bur_act <= 1'b0;
            end
         end else if ((op_run == ddrcmd_pkg::ddrcmd_op_rd ||
                       op_run == ddrcmd_pkg::ddrcmd_op_wr) &&
                      bstate[ba2] == ddrcmd_pkg::ddrcmd_bank_act) begin
            bur_act <= 1'b1;
            bur_wr <= (op == ddrcmd_pkg::ddrcmd_op_wr);
            bur_ap <= a2[`DDRCMD_A10];
            bur_bank <= ba2;
            bur_left <= next_len;
            bur_addr <= next_addr;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (clk_en && bur_act && bur_wr && !dm2)
         mem[bur_addr] <= dq2;
   end

   ddrcmd_buf2 u_buf (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .in_data(mem[bur_addr]),
      .in_valid(rd_push),
      .in_ready(buf_in_ready),
      .out_data(buf_out_data),
      .out_valid(buf_out_valid),
      .out_ready(out_take)
   );

   // Output stage only advances when empty or taken, so a stall loses no word
   assign out_take = !rd_valid || rd_ready;

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         rd_data <= '0;
         rd_valid <= 1'b0;
      end else if (clk_en && out_take) begin
         rd_data <= buf_out_data;
         rd_valid <= buf_out_valid;
      end
   end

   // Refresh, self refresh and calibration timing
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         mode <= ddrcmd_pkg::ddrcmd_mode_run;
         busy_cnt <= 9'h0;
         sr_cnt <= 10'h0;
         ref_row <= '0;
         zq_init_done <= 1'b0;
         zq_work <= `DDRCMD_ZQ_RST;
         zq_value <= `DDRCMD_ZQ_RST;
         zq_busy <= 1'b0;
      end else if (clk_en) begin
         case (mode)
            ddrcmd_pkg::ddrcmd_mode_run: begin
               if (op == ddrcmd_pkg::ddrcmd_op_ref) begin
                  ref_row <= ref_row + 1'b1;
                  busy_cnt <= 9'(`DDRCMD_T_RFC_CK);
                  mode <= ddrcmd_pkg::ddrcmd_mode_busy;
               end else if (op == ddrcmd_pkg::ddrcmd_op_sre) begin
                  mode <= ddrcmd_pkg::ddrcmd_mode_self;
                  sr_cnt <= 10'h0;
               end else if (op == ddrcmd_pkg::ddrcmd_op_zql) begin
                  busy_cnt <= zq_init_done ? 9'(`DDRCMD_T_ZQOPER_CK) :
                              9'(`DDRCMD_T_ZQINIT_CK - 1);
                  zq_init_done <= 1'b1;
                  zq_work <= zq_value + 8'h1;
                  zq_busy <= 1'b1;
                  mode <= ddrcmd_pkg::ddrcmd_mode_busy;
               end else if (op == ddrcmd_pkg::ddrcmd_op_zqs) begin
                  busy_cnt <= 9'(`DDRCMD_T_ZQCS_CK);
                  zq_work <= zq_value + 8'h1;
                  zq_busy <= 1'b1;
                  mode <= ddrcmd_pkg::ddrcmd_mode_busy;
               end
            end
            ddrcmd_pkg::ddrcmd_mode_busy: begin
               if (busy_cnt <= 9'h1) begin
                  mode <= ddrcmd_pkg::ddrcmd_mode_run;
                  busy_cnt <= 9'h0;
                  if (zq_busy) zq_value <= zq_work;
                  zq_busy <= 1'b0;
               end else begin
                  busy_cnt <= busy_cnt - 9'h1;
               end
            end
            ddrcmd_pkg::ddrcmd_mode_self: begin
               if (sr_cnt == 10'(`DDRCMD_SR_TICK_CK - 1)) begin
                  sr_cnt <= 10'h0;
                  ref_row <= ref_row + 1'b1;
               end else begin
                  sr_cnt <= sr_cnt + 10'h1;
               end
               if (s2[4] && !cke_prev) mode <= ddrcmd_pkg::ddrcmd_mode_run;
            end
            default: mode <= ddrcmd_pkg::ddrcmd_mode_run;
         endcase
      end
   end

   // Flags controller misuse seen at the pins
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         cmd_error <= 1'b0;
         bank_open <= '0;
         self_refresh <= 1'b0;
      end else if (clk_en) begin
         cmd_error <= (op != ddrcmd_pkg::ddrcmd_op_none &&
                       mode == ddrcmd_pkg::ddrcmd_mode_busy) ||
                      (op == ddrcmd_pkg::ddrcmd_op_act &&
                       bstate[ba2] != ddrcmd_pkg::ddrcmd_bank_idle) ||
                      ((op == ddrcmd_pkg::ddrcmd_op_rd || op == ddrcmd_pkg::ddrcmd_op_wr) &&
                       (bstate[ba2] != ddrcmd_pkg::ddrcmd_bank_act || bur_act));
         for (int i = 0; i < `DDRCMD_NBANK; i++)
            bank_open[i] <= (bstate[i] == ddrcmd_pkg::ddrcmd_bank_act);
         self_refresh <= (mode == ddrcmd_pkg::ddrcmd_mode_self);
      end
   end
endmodule

// File: bench/ddrcmd_core_checker.sv
`timescale 1ns/1ps
module ddrcmd_chk (
   input wire logic clk_sys, // Clock
   input wire logic sys_rst, // Reset
   input wire logic cs_n_pin, // Select
   input wire logic ras_n_pin, // Row strobe
   input wire logic cas_n_pin, // Column strobe
   input wire logic we_n_pin, // Write strobe
   input wire logic cke_pin, // Clock enable
   input wire logic [7:0] rd_data, // Read word
   input wire logic rd_valid, // Read valid
   input wire logic rd_ready, // Read ready
   input wire logic [7:0] zq_value, // Impedance code
   input wire logic zq_busy, // Calibrating
   input wire logic [7:0] bank_open, // Open banks
   input wire logic self_refresh, // Self refresh
   input wire logic [15:0] ref_row, // Refresh row
   input wire logic cmd_error // Refused command
);
   logic [9:0] busy_len;
   logic [6:0] act_hist;
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         busy_len <= 10'h0;
         act_hist <= 7'h0;
      end else begin
         busy_len <= zq_busy ? busy_len + 10'h1 : 10'h0;
         act_hist <= {act_hist[5:0], !cs_n_pin && !ras_n_pin && cas_n_pin && we_n_pin};
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   sequence s_new_open;
      (bank_open & ~$past(bank_open)) != 8'h0;
   endsequence
   sequence s_zq_end;
      $fell(zq_busy);
   endsequence
   property p_open_cause;
      s_new_open |-> act_hist != 7'h0;
   endproperty
   property p_zq_hold;
      $changed(zq_value) |-> $past(zq_busy) || $past(zq_busy, 2);
   endproperty
   property p_zq_step;
      $changed(zq_value) |-> zq_value == $past(zq_value) + 8'h1;
   endproperty
   property p_zq_len;
      s_zq_end |-> busy_len inside {[60:64], [250:256], [500:512]};
   endproperty
   property p_desel;
      cs_n_pin [*6] |-> !cmd_error && !$rose(zq_busy);
   endproperty
   property p_rd_hold;
      rd_valid && !rd_ready |=> rd_valid && $stable(rd_data);
   endproperty
   property p_ref_step;
      $changed(ref_row) |-> ref_row == $past(ref_row) + 16'h1;
   endproperty
   property p_sr_cke;
      $rose(self_refresh) |-> !cke_pin;
   endproperty
   a_open_cause: assert property (p_open_cause) else $error("bank opened without activate");
   a_zq_hold: assert property (p_zq_hold) else $error("code moved outside calibration end");
   a_zq_step: assert property (p_zq_step) else $error("code step is not one");
   a_zq_len: assert property (p_zq_len) else $error("calibration busy length wrong");
   a_desel: assert property (p_desel) else $error("deselect caused an action");
   a_rd_hold: assert property (p_rd_hold) else $error("read word lost in stall");
   a_ref_step: assert property (p_ref_step) else $error("refresh row not incremented");
   a_sr_cke: assert property (p_sr_cke) else $error("self refresh without low cke");
endmodule

// File: bench/ddrcmd_ctl_model.sv
`timescale 1ns/1ps
module ddrcmd_ctl_model (
   input wire logic clk_sys, // Clock
   output logic cs_n_pin, // Select
   output logic ras_n_pin, // Row strobe
   output logic cas_n_pin, // Column strobe
   output logic we_n_pin, // Write strobe
   output logic cke_pin, // Clock enable
   output logic [2:0] ba_pin, // Bank
   output logic [15:0] addr_pin, // Address
   output logic [7:0] dq_in_pin, // Write data
   output logic dm_pin // Mask
);
   initial begin
      cs_n_pin = 1'b1;
      {ras_n_pin, cas_n_pin, we_n_pin} = 3'h7;
      cke_pin = 1'b1;
      ba_pin = 3'h0;
      addr_pin = 16'h0;
      dq_in_pin = 8'h0;
      dm_pin = 1'b0;
   end
   // One command, then n write beats one cycle later; released lines show inverted levels
   task automatic issue(input logic sel_n, input logic [2:0] rcw, input logic [2:0] ba,
         input logic [15:0] a, input logic cke, input logic [63:0] d, input logic [7:0] m,
         input int n);
      @(posedge clk_sys);
      #1;
      cs_n_pin = sel_n;
      {ras_n_pin, cas_n_pin, we_n_pin} = rcw;
      ba_pin = ba;
      addr_pin = a;
      cke_pin = cke;
      for (int k = 0; k < (n > 0 ? n + 1 : 1); k++) begin
         dq_in_pin = (n > 0 && k > 0) ? d[8*(k-1)+:8] : ~dq_in_pin;
         dm_pin = (n > 0 && k > 0) ? m[k-1] : ~dm_pin;
         @(posedge clk_sys);
         #1;
         cs_n_pin = 1'b1;
      end
      ba_pin = ~ba_pin;
      addr_pin = ~addr_pin;
      dq_in_pin = ~dq_in_pin;
      dm_pin = ~dm_pin;
   endtask
endmodule

// File: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   localparam logic [2:0] c_ref = 3'h1, c_pre = 3'h2, c_act = 3'h3, c_wr = 3'h4, c_rd = 3'h5;
   localparam logic [63:0] pat_a = 64'h8877665544332211, pat_b = 64'hf0e0d0c0b0a09080;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic clk_en = 1'b1;
   logic otf_en = 1'b1;
   logic bc4_fixed = 1'b0;
   logic rd_ready = 1'b1;
   logic cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin, cke_pin, dm_pin;
   logic rd_valid, zq_busy, self_refresh, cmd_error;
   logic [2:0] ba_pin;
   logic [7:0] dq_in_pin, rd_data, zq_value, bank_open;
   logic [15:0] addr_pin, ref_row, row0;
   logic [7:0] got [0:7];
   int err_total = 0;
   int n_checks = 0;
   int n_refused = 0;
   int n_got;
   always #10 clk_sys = ~clk_sys;
   always @(posedge clk_sys)
      if (cmd_error === 1'b1) n_refused++;
   ddrcmd_core uut (.clk_sys, .sys_rst, .clk_en, .cs_n_pin, .ras_n_pin, .cas_n_pin,
      .we_n_pin, .cke_pin, .ba_pin, .addr_pin, .dq_in_pin, .dm_pin, .otf_en, .bc4_fixed,
      .rd_data, .rd_valid, .rd_ready, .zq_value, .zq_busy, .bank_open, .self_refresh,
      .ref_row, .cmd_error);
   ddrcmd_ctl_model u_ctl (.clk_sys, .cs_n_pin, .ras_n_pin, .cas_n_pin, .we_n_pin,
      .cke_pin, .ba_pin, .addr_pin, .dq_in_pin, .dm_pin);
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic cmd(input logic [2:0] rcw, input logic [2:0] ba, input logic [15:0] a);
      u_ctl.issue(1'b0, rcw, ba, a, 1'b1, 64'h0, 8'h0, 0);
   endtask
   task automatic rd(input logic [2:0] ba, input logic [15:0] a, input int stall);
      cmd(c_rd, ba, a);
      n_got = 0;
      for (int c = 1; c < 60 && n_got < 8; c++) begin
         @(negedge clk_sys);
         if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
            got[n_got] = rd_data;
            n_got++;
         end
         @(posedge clk_sys);
         #1;
         rd_ready = (c % stall) != 0;
      end
      rd_ready = 1'b1;
   endtask
   task automatic t_open();
      chk(zq_value, 8'h40);
      chk(bank_open, 8'h00);
      u_ctl.issue(1'b1, c_act, 3'h3, 16'h0002, 1'b1, 64'h0, 8'h0, 0);
      idle(8);
      chk(bank_open, 8'h00);
      cmd(c_act, 3'h3, 16'h0002);
      idle(6);
      chk(bank_open, 8'h08);
      cmd(c_act, 3'h3, 16'h0001);
      idle(6);
      chk(n_refused, 1);
   endtask
   task automatic t_data();
      u_ctl.issue(1'b0, c_wr, 3'h3, 16'h1000, 1'b1, pat_a, 8'h00, 8);
      idle(10);
      u_ctl.issue(1'b0, c_wr, 3'h3, 16'h1000, 1'b1, pat_b, 8'h22, 8);
      idle(10);
      rd(3'h3, 16'h1000, 3);
      chk(n_got, 8);
      for (int k = 0; k < 8; k++) begin
         chk(got[k], k % 4 == 1 ? pat_a[8*k+:8] : pat_b[8*k+:8]);
      end
      rd(3'h3, 16'h0000, 99);
      chk(n_got, 4);
      chk(got[3], pat_b[31:24]);
      otf_en = 1'b0;
      bc4_fixed = 1'b1;
      rd(3'h3, 16'h1000, 99);
      chk(n_got, 4);
      otf_en = 1'b1;
      bc4_fixed = 1'b0;
      rd(3'h3, 16'h1400, 99);
      idle(4);
      chk(bank_open, 8'h00);
   endtask
   task automatic t_bank();
      int e0;
      e0 = n_refused;
      rd(3'h3, 16'h1000, 99);
      chk(n_got, 0);
      cmd(c_pre, 3'h3, 16'h0000);
      cmd(c_act, 3'h1, 16'h0003);
      cmd(c_act, 3'h5, 16'h0001);
      idle(6);
      chk(n_refused, e0 + 1);
      chk(bank_open, 8'h22);
      rd(3'h1, 16'h1400, 99);
      rd(3'h5, 16'h1000, 99);
      chk(n_got, 8);
      chk(bank_open, 8'h20);
      cmd(c_act, 3'h1, 16'h0000);
      cmd(c_pre, 3'h5, 16'h0000);
      idle(4);
      chk(bank_open, 8'h02);
      cmd(c_pre, 3'h6, 16'h0400);
      idle(4);
      chk(bank_open, 8'h00);
   endtask
   task automatic t_refresh();
      int e0;
      e0 = n_refused;
      row0 = ref_row;
      cmd(c_ref, 3'h0, 16'h0000);
      cmd(c_act, 3'h2, 16'h0000);
      idle(16);
      chk(bank_open, 8'h00);
      chk(n_refused, e0 + 1);
      chk(ref_row, row0 + 16'h1);
   endtask
   task automatic zq(input logic [15:0] a, input int lo, input int hi, input logic [7:0] v);
      int n;
      n = 0;
      cmd(3'h6, 3'h0, a);
      for (int c = 0; c < 600 && (n == 0 || zq_busy === 1'b1); c++) begin
         @(negedge clk_sys);
         n += (zq_busy === 1'b1);
      end
      chk(n >= lo && n <= hi, 1'b1);
      chk(zq_value, v);
   endtask
   task automatic t_self();
      row0 = ref_row;
      u_ctl.issue(1'b0, c_ref, 3'h0, 16'h0000, 1'b0, 64'h0, 8'h0, 0);
      idle(800);
      chk(self_refresh, 1'b1);
      chk(ref_row - row0 >= 2 && ref_row - row0 <= 3, 1'b1);
      u_ctl.issue(1'b1, 3'h7, 3'h0, 16'h0000, 1'b1, 64'h0, 8'h0, 0);
      idle(10);
      chk(self_refresh, 1'b0);
   endtask
   task automatic tally_and_finish();
      if (err_total == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk_sys);
      #1;
      sys_rst = 1'b0;
      t_open();
      t_data();
      t_bank();
      t_refresh();
      zq(16'h0000, 60, 64, 8'h41);
      zq(16'h0400, 500, 512, 8'h42);
      zq(16'h0400, 250, 256, 8'h43);
      t_self();
      tally_and_finish();
   end
   initial begin
      #200000;
      err_total++;
      tally_and_finish();
   end
endmodule
bind ddrcmd_core ddrcmd_chk u_chk (.clk_sys, .sys_rst, .cs_n_pin, .ras_n_pin, .cas_n_pin,
   .we_n_pin, .cke_pin, .rd_data, .rd_valid, .rd_ready, .zq_value, .zq_busy, .bank_open,
   .self_refresh, .ref_row, .cmd_error);
